// file: logic/poll_master_pkg.sv
// constants, types and register map of the polling master
package poll_master_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_TIME0  = 8'h04;
    localparam logic [7:0]  ADDR_TIME1  = 8'h08;
    localparam logic [7:0]  ADDR_DEST   = 8'h0c;
    localparam logic [7:0]  ADDR_CMD    = 8'h10;
    localparam logic [7:0]  ADDR_STATUS = 8'h14;
    localparam logic [7:0]  ADDR_UNDEL  = 8'h18;
    localparam logic [7:0]  ADDR_LASTRX = 8'h1c;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_CRC    = 0;
    localparam int          CTRL_ALLOW  = 1;
    localparam int          CTRL_DUP    = 2;
    localparam int          T0_REPLY    = 0;
    localparam int          T0_ACKTO    = 8;
    localparam int          T0_OFF      = 16;
    localparam int          T0_SEND     = 24;
    localparam int          T1_PRE      = 0;
    localparam int          T1_RETRY    = 8;
    localparam int          CMD_START   = 0;
    localparam int          STS_BUSY    = 0;
    localparam int          STS_DONE    = 1;
    localparam int          STS_FAIL    = 2;
    localparam int          STS_REFUSED = 3;
    localparam int          STS_RTS     = 4;
    localparam int          STS_CTS     = 5;
    localparam logic [2:0]  CTRL_RST    = 3'h0;
    localparam logic [31:0] TIME0_RST   = 32'h0100_3205;
    localparam logic [15:0] TIME1_RST   = 16'h0300;
    localparam logic [7:0]  DEST_RST    = 8'h00;
    localparam logic [7:0]  BCAST_ADDR  = 8'hff;
    localparam logic [15:0] CRC_POLY    = 16'ha001;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ      = 125_000_000;
    localparam int          TICK_MS     = 1;
    localparam int          LONG_UNIT_MS = 20;
    localparam int          MS_CYC_DEF  = CLK_HZ / 1000 * TICK_MS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TX_MSG = 2'h0, TX_POLL = 2'h1, TX_ACK = 2'h2} tx_kind_e;
    typedef enum logic [1:0] {RX_ACK = 2'h0, RX_MSG = 2'h1, RX_EMPTY = 2'h2} rx_kind_e;
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01, ST_PRE   = 8'h02, ST_SEND  = 8'h04, ST_TX = 8'h08,
        ST_OFF   = 8'h10, ST_ACKW  = 8'h20, ST_RWAIT = 8'h40, ST_POLLW = 8'h80
    } state_e;
    typedef struct packed {
        tx_kind_e   kind;
        logic [7:0] dest;
    } tx_req_s;
    typedef struct packed {
        rx_kind_e    kind;
        logic [7:0]  src;
        logic        reply;
        logic [15:0] chk;
    } rx_pkt_s;
endpackage : poll_master_pkg

// file: logic/half_duplex_poll_master_msg.sv
// message-based master of a half-duplex polled serial link
`timescale 1ns/1ns
`default_nettype none
module half_duplex_poll_master_msg #(
    parameter int unsigned MS_CYCLES = poll_master_pkg::MS_CYC_DEF
) (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // modem handshake
    input  wire logic                    cts,
    output logic                         rts,
    // framer transmit side
    output logic                         tx_start,
    output poll_master_pkg::tx_req_s     tx_req,
    output logic                         tx_gate,
    input  wire logic                    tx_done,
    // framer receive side
    input  wire logic                    rx_byte_valid,
    input  wire logic [7:0]              rx_byte,
    input  wire logic                    rx_pkt_valid,
    input  wire poll_master_pkg::rx_pkt_s rx_pkt,
    // delivered messages
    output logic                         exec_valid,
    output logic [7:0]                   exec_src,
    output logic                         exec_unsol
);
    import poll_master_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_e      st, next_st, after_ack, next_after_ack;
    logic [2:0]  ctrl, next_ctrl;
    logic [31:0] time0, next_time0;
    logic [15:0] time1, next_time1;
    logic [7:0]  dest, next_dest;
    logic        start_pend, next_start_pend;
    logic        done_f, next_done_f, fail_f, next_fail_f;
    logic        refused_f, next_refused_f;
    logic [15:0] undel, next_undel;
    logic [31:0] cyc_cnt, next_cyc_cnt;
    logic [15:0] ms_cnt, next_ms_cnt;
    logic        started, next_started;
    logic [7:0]  retry, next_retry;
    logic        last_v, next_last_v;
    logic [7:0]  last_src, next_last_src;
    logic [15:0] last_chk, next_last_chk;
    logic        hold_v, next_hold_v;
    logic [7:0]  hold_src, next_hold_src;
    logic [7:0]  sum, next_sum;
    logic [15:0] crc, next_crc;
    logic        cts_m1, cts_m2, cts_m3, cts_q, next_cts_q;
    logic        next_rts, next_tx_start, next_tx_gate;
    tx_req_s     next_tx_req;
    logic        next_exec_valid, next_exec_unsol;
    logic [7:0]  next_exec_src;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    // working terms
    logic        tick, dly_done, good, is_dup, acc, wr;
    logic [15:0] wait_ms;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    function automatic logic [15:0] long_ms(input logic [7:0] v);
        return 16'(v) * 16'(LONG_UNIT_MS);
    endfunction : long_ms

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;          next_after_ack = after_ack;
        next_ctrl = ctrl;      next_time0 = time0;
        next_time1 = time1;    next_dest = dest;
        next_start_pend = start_pend;
        next_done_f = done_f;  next_fail_f = fail_f;
        next_refused_f = refused_f;
        next_undel = undel;    next_started = started;
        next_retry = retry;
        next_last_v = last_v;  next_last_src = last_src;
        next_last_chk = last_chk;
        next_hold_v = hold_v;  next_hold_src = hold_src;
        next_sum = sum;        next_crc = crc;
        next_rts = rts;        next_tx_start = 1'b0;
        next_tx_req = tx_req;  next_tx_gate = 1'b0;
        next_exec_valid = 1'b0;
        next_exec_src = exec_src;
        next_exec_unsol = exec_unsol;
        next_prdata = prdata;  next_pslverr = 1'b0;
        // glitch filter: the late stages must agree
        next_cts_q = (cts_m2 == cts_m3) ? cts_m3 : cts_q;

        // millisecond tick and state timer
        tick = (cyc_cnt == MS_CYCLES - 1);
        next_cyc_cnt = tick ? 32'h0 : cyc_cnt + 32'h1;
        next_ms_cnt = (tick && ms_cnt != 16'hffff) ? ms_cnt + 16'h1 : ms_cnt;
        case (st)
            ST_PRE:   wait_ms = 16'(time1[T1_PRE +: 8]);
            ST_SEND:  wait_ms = long_ms(time0[T0_SEND +: 8]);
            ST_OFF:   wait_ms = long_ms(time0[T0_OFF +: 8]);
            ST_RWAIT: wait_ms = long_ms(time0[T0_REPLY +: 8]);
            ST_ACKW,
            ST_POLLW: wait_ms = long_ms(time0[T0_ACKTO +: 8]);
            default:  wait_ms = 16'h0;
        endcase
        dly_done = (ms_cnt >= wait_ms);

        // receive check: sum is blind to order and zero bytes, crc is not
        good = 1'b0;
        is_dup = 1'b0;
        if (rx_byte_valid) begin
            next_sum = sum + rx_byte;
            next_crc = crc_step(crc, rx_byte);
        end
        if (rx_pkt_valid) begin
            good = ctrl[CTRL_CRC] ? (crc == rx_pkt.chk)
                                  : (8'(sum + rx_pkt.chk[7:0]) == 8'h00);
            is_dup = ctrl[CTRL_DUP] && last_v && last_src == rx_pkt.src
                     && last_chk == rx_pkt.chk;
            next_sum = 8'h00;
            next_crc = 16'h0000;
        end

        // link sequencer
        case (st)
            ST_IDLE: begin
                if (start_pend) begin
                    next_start_pend = 1'b0;
                    next_retry = 8'h00;
                    next_tx_req = '{kind: TX_MSG, dest: dest};
                    next_st = ST_PRE;
                end else if (hold_v) begin
                    // slave traffic only after own messages are through
                    next_hold_v = 1'b0;
                    next_exec_valid = 1'b1;
                    next_exec_src = hold_src;
                    next_exec_unsol = 1'b1;
                end
            end
            ST_PRE: if (dly_done) begin
                next_rts = 1'b1;
                next_st = ST_SEND;
            end
            ST_SEND: if (dly_done) begin
                next_started = 1'b0;
                next_st = ST_TX;
            end
            ST_TX: begin
                next_tx_gate = cts_q;
                if (!started && cts_q) begin
                    next_tx_start = 1'b1;
                    next_started = 1'b1;
                end else if (started && tx_done) begin
                    next_st = ST_OFF;
                end
            end
            ST_OFF: if (dly_done) begin
                next_rts = 1'b0;
                case (tx_req.kind)
                    TX_MSG:  next_st = ST_ACKW;
                    TX_POLL: next_st = ST_POLLW;
                    default: next_st = after_ack;
                endcase
            end
            ST_ACKW: begin
                if (rx_pkt_valid && good && rx_pkt.kind == RX_ACK
                    && rx_pkt.src == tx_req.dest) begin
                    next_retry = 8'h00;
                    next_st = ST_RWAIT;
                end else if (dly_done) begin
                    if (retry < time1[T1_RETRY +: 8]) begin
                        next_retry = retry + 8'h01;
                        next_st = ST_PRE;
                    end else begin
                        next_fail_f = 1'b1;
                        next_undel = undel + 16'h1;
                        next_st = ST_IDLE;
                    end
                end
            end
            ST_RWAIT: if (dly_done) begin
                next_tx_req = '{kind: TX_POLL, dest: tx_req.dest};
                next_st = ST_PRE;
            end
            ST_POLLW: begin
                if (rx_pkt_valid && good && rx_pkt.src == tx_req.dest
                    && rx_pkt.kind == RX_MSG) begin
                    // every good message from the polled station is acked, whatever happens to it
                    next_tx_req = '{kind: TX_ACK, dest: rx_pkt.src};
                    next_last_v = 1'b1;
                    next_last_src = rx_pkt.src;
                    next_last_chk = rx_pkt.chk;
                    next_st = ST_PRE;
                    if (rx_pkt.reply) begin
                        next_after_ack = ST_IDLE;
                        next_done_f = 1'b1;
                        next_exec_valid = !is_dup;
                        next_exec_src = rx_pkt.src;
                        next_exec_unsol = 1'b0;
                    end else begin
                        // reply still owed: poll again after the ack
                        next_after_ack = ST_RWAIT;
                        if (ctrl[CTRL_ALLOW] && !is_dup) begin
                            next_hold_v = 1'b1;
                            next_hold_src = rx_pkt.src;
                        end
                    end
                end else if ((rx_pkt_valid && good && rx_pkt.kind == RX_EMPTY
                              && rx_pkt.src == tx_req.dest) || dly_done) begin
                    if (retry < time1[T1_RETRY +: 8]) begin
                        next_retry = retry + 8'h01;
                        next_st = ST_RWAIT;
                    end else begin
                        next_fail_f = 1'b1;
                        next_st = ST_IDLE;
                    end
                end
            end
            default: next_st = ST_IDLE;
        endcase
        if (next_st != st) next_ms_cnt = 16'h0;

        // apb: two-cycle access, write lands on the pready edge
        acc = psel && penable;
        wr = acc && pready && pwrite;
        next_pready = acc && !pready;
        if (acc && !pready) begin
            case (paddr)
                ADDR_CTRL:   next_prdata = {29'h0, ctrl};
                ADDR_TIME0:  next_prdata = time0;
                ADDR_TIME1:  next_prdata = {16'h0, time1};
                ADDR_DEST:   next_prdata = {24'h0, dest};
                ADDR_CMD:    next_prdata = 32'h0;
                ADDR_STATUS: next_prdata = {26'h0, cts_q, rts, refused_f, fail_f,
                                            done_f, (st != ST_IDLE) || start_pend};
                ADDR_UNDEL:  next_prdata = {16'h0, undel};
                ADDR_LASTRX: next_prdata = {7'h0, last_v, last_src, last_chk};
                default: begin
                    next_prdata = 32'h0;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (wr) begin
            case (paddr)
                ADDR_CTRL:  next_ctrl = pwdata[2:0];
                ADDR_TIME0: next_time0 = pwdata;
                ADDR_TIME1: next_time1 = pwdata[15:0];
                ADDR_DEST:  next_dest = pwdata[7:0];
                ADDR_CMD: if (pwdata[CMD_START]) begin
                    // broadcast is never a single station's address
                    if (dest == BCAST_ADDR || start_pend || st != ST_IDLE)
                        next_refused_f = 1'b1;
                    else
                        next_start_pend = 1'b1;
                end
                ADDR_STATUS: begin
                    // write one to clear; a same-cycle hardware set wins
                    if (pwdata[STS_DONE] && !(next_done_f && !done_f))
                        next_done_f = 1'b0;
                    if (pwdata[STS_FAIL] && !(next_fail_f && !fail_f))
                        next_fail_f = 1'b0;
                    if (pwdata[STS_REFUSED] && !(next_refused_f && !refused_f))
                        next_refused_f = 1'b0;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_IDLE;         after_ack <= ST_IDLE;
            ctrl <= CTRL_RST;      time0 <= TIME0_RST;
            time1 <= TIME1_RST;    dest <= DEST_RST;
            start_pend <= 1'b0;    done_f <= 1'b0;
            fail_f <= 1'b0;        refused_f <= 1'b0;
            undel <= 16'h0;        cyc_cnt <= 32'h0;
            ms_cnt <= 16'h0;       started <= 1'b0;
            retry <= 8'h00;        last_v <= 1'b0;
            last_src <= 8'h00;     last_chk <= 16'h0;
            hold_v <= 1'b0;        hold_src <= 8'h00;
            sum <= 8'h00;          crc <= 16'h0;
            cts_m1 <= 1'b0;        cts_m2 <= 1'b0;
            cts_m3 <= 1'b0;        cts_q <= 1'b0;
            rts <= 1'b0;           tx_start <= 1'b0;
            tx_req <= '{kind: TX_MSG, dest: 8'h00};
            tx_gate <= 1'b0;       exec_valid <= 1'b0;
            exec_src <= 8'h00;     exec_unsol <= 1'b0;
            prdata <= 32'h0;       pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            st <= next_st;         after_ack <= next_after_ack;
            ctrl <= next_ctrl;     time0 <= next_time0;
            time1 <= next_time1;   dest <= next_dest;
            start_pend <= next_start_pend;
            done_f <= next_done_f; fail_f <= next_fail_f;
            refused_f <= next_refused_f;
            undel <= next_undel;   cyc_cnt <= next_cyc_cnt;
            ms_cnt <= next_ms_cnt; started <= next_started;
            retry <= next_retry;   last_v <= next_last_v;
            last_src <= next_last_src;
            last_chk <= next_last_chk;
            hold_v <= next_hold_v; hold_src <= next_hold_src;
            sum <= next_sum;       crc <= next_crc;
            cts_m1 <= cts;         cts_m2 <= cts_m1;
            cts_m3 <= cts_m2;      cts_q <= next_cts_q;
            rts <= next_rts;       tx_start <= next_tx_start;
            tx_req <= next_tx_req; tx_gate <= next_tx_gate;
            exec_valid <= next_exec_valid;
            exec_src <= next_exec_src;
            exec_unsol <= next_exec_unsol;
            prdata <= next_prdata; pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule : half_duplex_poll_master_msg
`default_nettype wire

// file: verif/poll_master_props.sv
// port checker for the polling master
`timescale 1ns/1ns
`default_nettype none
module poll_master_props #(
    parameter int unsigned MS_CYCLES = 4
) (
    // apb
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // link
    input wire logic                     rts,
    input wire logic                     tx_start,
    input wire poll_master_pkg::tx_req_s tx_req,
    input wire logic                     tx_gate
);
    import poll_master_pkg::*;
    // ----------------------------------------
    // last message target, for poll checks
    // ----------------------------------------
    logic       msg_seen;
    logic [7:0] msg_dest;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_seen <= 1'b0;
            msg_dest <= 8'h00;
        end else if (tx_start && tx_req.kind == TX_MSG) begin
            msg_seen <= 1'b1;
            msg_dest <= tx_req.dest;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_LATE: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    AST_PREADY_ONCE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR_READY: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside a completing access");
    AST_GATE_RTS: assert property (tx_gate |-> rts)
        else $error("transmit gate open without rts");
    AST_START_RTS: assert property (tx_start |-> rts ##1 !tx_start [*2])
        else $error("bad transmit start");
    AST_REQ_STABLE: assert property (tx_gate && $past(tx_gate) |-> $stable(tx_req))
        else $error("request changed while sending");
    AST_POLL_AFTER_MSG: assert property (tx_start && tx_req.kind == TX_POLL
        |-> msg_seen && tx_req.dest == msg_dest)
        else $error("poll to a slave not sent a message");
    AST_NO_BCAST: assert property (tx_start && tx_req.kind != TX_ACK
        |-> tx_req.dest != BCAST_ADDR)
        else $error("broadcast address used as target");
endmodule : poll_master_props
bind half_duplex_poll_master_msg poll_master_props #(.MS_CYCLES(MS_CYCLES)) props_i (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .rts, .tx_start, .tx_req, .tx_gate
);
`default_nettype wire

// file: verif/slave_station_model.sv
// slave station, modem and framer stand-in on the far side
`timescale 1ns/1ns
`default_nettype none
module slave_station_model (
    // control
    input  wire logic                     pclk,
    input  wire logic                     mute,
    input  wire logic                     unsol,
    input  wire logic                     crc_on,
    // master side
    input  wire logic                     rts,
    input  wire logic                     tx_start,
    input  wire poll_master_pkg::tx_req_s tx_req,
    input  wire logic                     tx_gate,
    output logic                          cts = 1'b0,
    output logic                          tx_done = 1'b0,
    output logic                          rx_byte_valid = 1'b0,
    output logic [7:0]                    rx_byte = 8'h00,
    output logic                          rx_pkt_valid = 1'b0,
    output poll_master_pkg::rx_pkt_s      rx_pkt = '0
);
    import poll_master_pkg::*;
    tx_req_s req;
    logic    pend = 1'b0;
    // reflected crc of a single byte from a zero start
    function automatic logic [15:0] crc_one(input logic [7:0] d);
        logic [15:0] r;
        r = {8'h00, d};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction : crc_one
    // one body byte, closed by the negated sum or the crc of that byte
    task automatic send(input rx_kind_e k, input logic [7:0] src, input logic [7:0] b,
                        input logic rep);
        rx_byte_valid <= 1'b1;
        rx_byte       <= b;
        @(posedge pclk);
        rx_byte_valid <= 1'b0;
        rx_byte       <= ~b;
        @(posedge pclk);
        rx_pkt_valid  <= 1'b1;
        rx_pkt        <= '{k, src, rep, crc_on ? crc_one(b) : {8'h00, 8'h00 - b}};
        @(posedge pclk);
        rx_pkt_valid  <= 1'b0;
        rx_pkt        <= '{RX_EMPTY, ~src, 1'b0, 16'hffff};
    endtask : send
    always @(posedge pclk) cts <= rts;
    always @(posedge pclk) begin
        if (tx_start) begin
            req = tx_req;
            repeat (3) @(posedge pclk);
            while (!tx_gate) @(posedge pclk);
            tx_done <= 1'b1;
            @(posedge pclk);
            tx_done <= 1'b0;
            // half duplex: answer only once the line is turned round
            while (rts) @(posedge pclk);
            repeat (6) @(posedge pclk);
            if (req.kind == TX_ACK) begin
                pend = 1'b0;
            end else if (!mute && req.kind == TX_MSG) begin
                // own message queued, offered at the next poll
                pend = unsol;
                send(RX_ACK, req.dest, 8'h06, 1'b1);
            end else if (!mute && req.kind == TX_POLL) begin
                send(RX_MSG, req.dest, pend ? 8'h5a : req.dest, !pend);
            end
        end
    end
endmodule : slave_station_model
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the polling master
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    import poll_master_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, cts, rts, tx_start, tx_gate, tx_done, exec_valid, err;
    logic        rx_byte_valid, rx_pkt_valid, exec_unsol, mute = 1'b0;
    logic        unsol = 1'b0, crc_on = 1'b0;
    logic [7:0]  paddr = 8'h00, rx_byte, exec_src;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    tx_req_s     tx_req;
    rx_pkt_s     rx_pkt;
    int          num_errors = 0, checks_done = 0, msgs = 0, execs = 0;
    always #4 pclk = ~pclk;
    half_duplex_poll_master_msg #(.MS_CYCLES(4)) DUT (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cts, .rts, .tx_start, .tx_req,
        .tx_gate, .tx_done, .rx_byte_valid, .rx_byte, .rx_pkt_valid, .rx_pkt, .exec_valid,
        .exec_src, .exec_unsol);
    slave_station_model far_i (.pclk, .mute, .unsol, .crc_on, .rts, .tx_start, .tx_req,
        .tx_gate, .cts, .tx_done, .rx_byte_valid, .rx_byte, .rx_pkt_valid, .rx_pkt);
    always @(posedge pclk) begin
        if (tx_start && tx_req.kind == TX_MSG) msgs++;
        if (exec_valid) execs++;
    end
    // ----------------------------------------
    // bus and scenarios
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) num_errors++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask : apb
    task automatic wait_sts(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(0, ADDR_STATUS, 0);
            n++;
        end while (rd[b] !== v && n < 3000);
        if (rd[b] !== v) num_errors++;
    endtask : wait_sts
    task automatic t_regs;
        apb(0, ADDR_CTRL, 0);
        `CHK("ctrl", {29'h0, CTRL_RST}, rd)
        apb(0, ADDR_TIME0, 0);
        `CHK("time0", TIME0_RST, rd)
        apb(0, ADDR_TIME1, 0);
        `CHK("time1", {16'h0, TIME1_RST}, rd)
        apb(0, 8'h40, 0);
        `CHK("unmapped", 1'b1, err)
    endtask : t_regs
    task automatic t_xfer(input logic [7:0] dest, input int exp, input logic un);
        int e0;
        e0 = execs;
        unsol <= un;
        apb(1, ADDR_DEST, {24'h0, dest});
        apb(1, ADDR_CMD, 32'h1);
        wait_sts(STS_DONE, 1'b1);
        `CHK("done", 1'b1, rd[STS_DONE])
        // done comes before the closing ack is out; a new start would be refused
        wait_sts(STS_BUSY, 1'b0);
        repeat (2) @(posedge pclk);
        `CHK("exec count", exp, execs - e0)
        `CHK("exec src", dest, exec_src)
        `CHK("exec unsol", un && exp > 1, exec_unsol)
        apb(1, ADDR_STATUS, 32'he);
    endtask : t_xfer
    task automatic t_fail;
        int m0, n;
        m0 = msgs;
        n = 0;
        mute <= 1'b1;
        apb(1, ADDR_DEST, 32'h07);
        apb(1, ADDR_CMD, 32'h1);
        while (rts !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        `CHK("pre delay", 1'b1, n >= 4 && n <= 14)
        wait_sts(STS_FAIL, 1'b1);
        mute <= 1'b0;
        `CHK("sends", 4, msgs - m0)
        apb(0, ADDR_UNDEL, 0);
        `CHK("undelivered", 32'h1, rd)
        apb(1, ADDR_STATUS, 32'he);
    endtask : t_fail
    task automatic t_bcast;
        int m0;
        m0 = msgs;
        apb(1, ADDR_DEST, {24'h0, BCAST_ADDR});
        apb(1, ADDR_CMD, 32'h1);
        apb(0, ADDR_STATUS, 0);
        `CHK("refused", 1'b1, rd[STS_REFUSED])
        `CHK("no send", 0, msgs - m0)
    endtask : t_bcast
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        // short timing: reply 1, ack timeout 2, off 1, send 0 (20 ms units), pre 2 ms, 3 retries
        apb(1, ADDR_TIME0, 32'h0001_0201);
        apb(1, ADDR_TIME1, 32'h0000_0302);
        t_xfer(8'h05, 1, 1'b0);
        t_xfer(8'h05, 1, 1'b0);
        apb(1, ADDR_CTRL, 32'h4);
        t_xfer(8'h05, 0, 1'b0);
        t_xfer(8'h09, 1, 1'b0);
        // crc check with slave traffic allowed, then the same traffic discarded
        apb(1, ADDR_CTRL, 32'h3);
        crc_on <= 1'b1;
        t_xfer(8'h0b, 2, 1'b1);
        apb(1, ADDR_CTRL, 32'h0);
        crc_on <= 1'b0;
        t_xfer(8'h0c, 1, 1'b1);
        t_fail();
        t_bcast();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
